// ### logic/vfi_core.sv
`timescale 1ns/1ps
// How it works
// - Pending flag reads one while its source requests; writing zero clears it.
// - Bit 7 watch timer, 6 reserved, 5..0 timer D1, D0, A match and overflow.
// - Reset clears every implemented pending bit; bit 6 is reserved.
// - Source sets request; core polls, checks level, acknowledges; logic supplies vector.
// - Service needs global enable, unmasked level, top priority, source enable.
// - Acknowledge only at instruction end, then an interrupt machine cycle.
// - Machine cycle first clears global enable, then saves state and vectors.
// - Push order: PC low, PC high, then status flags.
// - Fetch vector high byte then low byte, branch to the 16-bit address.
// - Vectors lie in 00h..FFh and start at even addresses.
// - Interrupt return restores PC and flags and sets global enable.
// - Source pending bit is not cleared by service entry; only a software write of zero clears it.
// - Fast pointer is a read/write pair at DAh high and DBh low.
// - Fast entry loads the PC in the same cycle as acknowledge, far sooner than normal vectored entry.
// - Fast level is mode bits 4..2; fast service active only while bit 1 is set.
// - Any of levels 0 to 7 may be chosen for fast service.
// - Fast entry swaps pointer and PC, shadows flags, sets fast service flag.
// - Fast return swaps back, restores flags from shadow, clears fast flag.
// - Shadow status copy is unaddressed and invisible to software.
// - Hardware-cleared level pendings clear after acknowledge and are unmapped.
// - Fast service flag is status bit 1: one while fast routine runs.
// - Global enable gates everything, fast service included; fast bit alone toggles it.
module vfi_core (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Peripheral events
	input wire logic [7:0] src_event,
	input wire logic [3:0] auto_event,
	output logic [3:0] auto_pending,
	// Winning request from mask and priority logic
	input wire logic win_valid,
	input wire logic [2:0] win_level,
	input wire logic [7:0] win_vector,
	// Core sequencer
	input wire logic instr_end,
	input wire logic ret_req,
	input wire logic gie_on,
	input wire logic gie_off,
	input wire logic [15:0] pc_in,
	input wire logic [7:0] flags_in,
	output logic irq_ack,
	output logic [2:0] ack_level,
	output logic busy,
	// Stack
	output logic push_en,
	output logic [7:0] push_data,
	output logic pop_en,
	input wire logic [7:0] pop_data,
	// Vector fetch
	output logic vec_rd_en,
	output logic [15:0] vec_rd_addr,
	input wire logic [7:0] vec_rd_data,
	// PC and flags load
	output logic pc_load,
	output logic [15:0] pc_value,
	output logic flags_load,
	output logic [7:0] flags_value,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic [7:0] sys_mode
);

	logic rst_s1_q;
	logic rst_n_q;
	vfi_pkg::vfi_state_t state_q;
	vfi_pkg::vfi_state_t state_d;
	logic [7:0] mode_q;
	logic [15:0] ptr_q;
	logic [7:0] shadow_q;
	logic [3:0] auto_q;
	logic [7:0] vec_q;
	logic [7:0] hi_q;
	logic [7:0] flg_q;
	logic [7:0] pend_flags;

	// Reset release through two flops
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_s1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q <= rst_s1_q;
		end
	end

	// Register decode
	wire wr_ptr_h = reg_wr & (reg_addr == vfi_pkg::ADDR_PTR_HIGH);
	wire wr_ptr_l = reg_wr & (reg_addr == vfi_pkg::ADDR_PTR_LOW);
	wire wr_pend = reg_wr & (reg_addr == vfi_pkg::ADDR_PEND);
	wire wr_mode = reg_wr & (reg_addr == vfi_pkg::ADDR_SYS_MODE);

	// Service decision
	wire idle = (state_q == vfi_pkg::ST_IDLE);
	wire gie = mode_q[vfi_pkg::MODE_GIE];
	wire [2:0] fast_sel = mode_q[vfi_pkg::MODE_FSEL_MSB:vfi_pkg::MODE_FSEL_LSB];
	wire take_ret = idle & instr_end & ret_req;
	wire take_irq = idle & instr_end & ~ret_req & win_valid & gie;
	wire is_fast = mode_q[vfi_pkg::MODE_FAST_EN] & (win_level == fast_sel);
	wire fast_ret = take_ret & flags_in[vfi_pkg::FLAG_FAST];
	wire [7:0] vec_even = {win_vector[7:1], 1'b0};

	vfi_pending u_pending (
		.clk(clk),
		.rst_n(rst_n_q),
		.src_event(src_event),
		.wr_en(wr_pend),
		.wr_data(reg_wdata),
		.flags(pend_flags)
	);

	// Next state
	always_comb begin
		state_d = state_q;
		case (state_q)
			vfi_pkg::ST_IDLE: begin
				if (take_ret && flags_in[vfi_pkg::FLAG_FAST]) begin
					state_d = vfi_pkg::ST_FAST;
				end else if (take_ret) begin
					state_d = vfi_pkg::ST_RET_FLG;
				end else if (take_irq && is_fast) begin
					state_d = vfi_pkg::ST_FAST;
				end else if (take_irq) begin
					state_d = vfi_pkg::ST_PUSH_PCL;
				end
			end
			vfi_pkg::ST_PUSH_PCL: state_d = vfi_pkg::ST_PUSH_PCH;
			vfi_pkg::ST_PUSH_PCH: state_d = vfi_pkg::ST_PUSH_FLG;
			vfi_pkg::ST_PUSH_FLG: state_d = vfi_pkg::ST_FETCH_HI;
			vfi_pkg::ST_FETCH_HI: state_d = vfi_pkg::ST_FETCH_LO;
			vfi_pkg::ST_FETCH_LO: state_d = vfi_pkg::ST_BRANCH;
			vfi_pkg::ST_BRANCH: state_d = vfi_pkg::ST_IDLE;
			vfi_pkg::ST_RET_FLG: state_d = vfi_pkg::ST_RET_PCH;
			vfi_pkg::ST_RET_PCH: state_d = vfi_pkg::ST_RET_PCL;
			vfi_pkg::ST_RET_PCL: state_d = vfi_pkg::ST_RET_DONE;
			vfi_pkg::ST_RET_DONE: state_d = vfi_pkg::ST_IDLE;
			vfi_pkg::ST_FAST: state_d = vfi_pkg::ST_IDLE;
			default: state_d = vfi_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= vfi_pkg::ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// System mode register: sequencer wins over software
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			mode_q <= vfi_pkg::MODE_RESET;
		end else if (take_irq) begin
			mode_q[vfi_pkg::MODE_GIE] <= 1'b0;
		end else if (take_ret) begin
			mode_q[vfi_pkg::MODE_GIE] <= 1'b1;
		end else if (gie_on || gie_off) begin
			mode_q[vfi_pkg::MODE_GIE] <= gie_on;
		end else if (wr_mode) begin
			mode_q <= reg_wdata;
		end
	end

	// Fast pointer: swap on fast entry and fast return, else software
	always_ff @(posedge clk) begin
		if ((take_irq && is_fast) || fast_ret) begin
			ptr_q <= pc_in;
		end else if (wr_ptr_h) begin
			ptr_q[15:8] <= reg_wdata;
		end else if (wr_ptr_l) begin
			ptr_q[7:0] <= reg_wdata;
		end
	end

	// Shadow status copy, never on the register port
	always_ff @(posedge clk) begin
		if (take_irq && is_fast) begin
			shadow_q <= flags_in;
		end
	end

	// Hardware-cleared level pendings; a new event beats the ack clear
	genvar g;
	generate
		for (g = 0; g < vfi_pkg::AUTO_LEVELS; g++) begin : g_auto
			always_ff @(posedge clk or negedge rst_n_q) begin
				if (!rst_n_q) begin
					auto_q[g] <= vfi_pkg::AUTO_RESET[g];
				end else begin
					auto_q[g] <= auto_event[g] |
						(auto_q[g] & ~(take_irq & (win_level == 3'(g))));
				end
			end
		end
	endgenerate
	assign auto_pending = auto_q;

	// Captured vector and data
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			vec_q <= 8'h00;
			hi_q <= 8'h00;
			flg_q <= 8'h00;
		end else begin
			if (take_irq) begin
				vec_q <= vec_even;
			end
			if (state_q == vfi_pkg::ST_FETCH_LO || state_q == vfi_pkg::ST_RET_PCL) begin
				hi_q <= (state_q == vfi_pkg::ST_FETCH_LO) ? vec_rd_data : pop_data;
			end
			if (state_q == vfi_pkg::ST_RET_PCH) begin
				flg_q <= pop_data;
			end
		end
	end

	// Acknowledge and sequencer outputs
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			irq_ack <= 1'b0;
			ack_level <= 3'h0;
			push_en <= 1'b0;
			push_data <= 8'h00;
			pop_en <= 1'b0;
			vec_rd_en <= 1'b0;
			vec_rd_addr <= 16'h0000;
		end else begin
			irq_ack <= take_irq;
			if (take_irq) begin
				ack_level <= win_level;
			end
			push_en <= (state_d == vfi_pkg::ST_PUSH_PCL) | (state_q == vfi_pkg::ST_PUSH_PCL) |
				(state_q == vfi_pkg::ST_PUSH_PCH);
			if (take_irq) begin
				push_data <= pc_in[7:0];
			end else if (state_q == vfi_pkg::ST_PUSH_PCL) begin
				push_data <= pc_in[15:8];
			end else if (state_q == vfi_pkg::ST_PUSH_PCH) begin
				push_data <= flags_in;
			end
			pop_en <= (take_ret & ~fast_ret) | (state_q == vfi_pkg::ST_RET_FLG) |
				(state_q == vfi_pkg::ST_RET_PCH);
			vec_rd_en <= (state_q == vfi_pkg::ST_PUSH_FLG) | (state_q == vfi_pkg::ST_FETCH_HI);
			if (state_q == vfi_pkg::ST_PUSH_FLG) begin
				vec_rd_addr <= {vfi_pkg::VEC_PAGE, vec_q};
			end else if (state_q == vfi_pkg::ST_FETCH_HI) begin
				vec_rd_addr <= {vfi_pkg::VEC_PAGE, vec_q[7:1], 1'b1};
			end
		end
	end

	// PC and flags loads
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pc_load <= 1'b0;
			pc_value <= 16'h0000;
			flags_load <= 1'b0;
			flags_value <= 8'h00;
		end else begin
			pc_load <= (take_irq & is_fast) | fast_ret | (state_q == vfi_pkg::ST_BRANCH) |
				(state_q == vfi_pkg::ST_RET_DONE);
			flags_load <= (take_irq & is_fast) | fast_ret | (state_q == vfi_pkg::ST_RET_DONE);
			if ((take_irq && is_fast) || fast_ret) begin
				pc_value <= ptr_q;
			end else if (state_q == vfi_pkg::ST_BRANCH) begin
				pc_value <= {hi_q, vec_rd_data};
			end else if (state_q == vfi_pkg::ST_RET_DONE) begin
				pc_value <= {hi_q, pop_data};
			end
			if (take_irq && is_fast) begin
				flags_value <= flags_in | (8'h01 << vfi_pkg::FLAG_FAST);
			end else if (fast_ret) begin
				flags_value <= shadow_q & ~(8'h01 << vfi_pkg::FLAG_FAST);
			end else if (state_q == vfi_pkg::ST_RET_DONE) begin
				flags_value <= flg_q;
			end
		end
	end

	// Register read port
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				vfi_pkg::ADDR_PTR_HIGH: reg_rdata <= ptr_q[15:8];
				vfi_pkg::ADDR_PTR_LOW: reg_rdata <= ptr_q[7:0];
				vfi_pkg::ADDR_PEND: reg_rdata <= pend_flags;
				vfi_pkg::ADDR_SYS_MODE: reg_rdata <= mode_q;
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	assign busy = ~idle;
	assign sys_mode = mode_q;

	property p_ack_needs_gie;
		@(posedge clk) disable iff (!rst_n_q)
		irq_ack |-> $past(instr_end) && $past(mode_q[vfi_pkg::MODE_GIE]);
	endproperty
	a_ack_needs_gie: assert property (p_ack_needs_gie) else $error("ack without enable");

	property p_ack_clears_gie;
		@(posedge clk) disable iff (!rst_n_q)
		irq_ack |-> !mode_q[vfi_pkg::MODE_GIE];
	endproperty
	a_ack_clears_gie: assert property (p_ack_clears_gie) else $error("enable kept on ack");

	property p_push_order;
		@(posedge clk) disable iff (!rst_n_q)
		(take_irq && !is_fast) ##1 1'b1 |-> push_en [*3] ##1 !push_en;
	endproperty
	a_push_order: assert property (p_push_order) else $error("three pushes expected");

	property p_push_first_low;
		@(posedge clk) disable iff (!rst_n_q)
		(take_irq && !is_fast) |=> push_data == $past(pc_in[7:0]);
	endproperty
	a_push_first_low: assert property (p_push_first_low) else $error("first push not PC low");

	property p_vec_even;
		@(posedge clk) disable iff (!rst_n_q)
		vec_rd_en && !$past(vec_rd_en) |-> vec_rd_addr[15:8] == 8'h00 && !vec_rd_addr[0];
	endproperty
	a_vec_even: assert property (p_vec_even) else $error("vector not even in low page");

	property p_normal_entry;
		@(posedge clk) disable iff (!rst_n_q)
		(take_irq && !is_fast) |-> ##7 pc_load;
	endproperty
	a_normal_entry: assert property (p_normal_entry) else $error("vector branch late");

	property p_fast_entry;
		@(posedge clk) disable iff (!rst_n_q)
		(take_irq && is_fast) |=> pc_load && pc_value == $past(ptr_q) && ptr_q == $past(pc_in)
			&& flags_value[vfi_pkg::FLAG_FAST];
	endproperty
	a_fast_entry: assert property (p_fast_entry) else $error("fast entry swap wrong");

	property p_fast_ret;
		@(posedge clk) disable iff (!rst_n_q)
		fast_ret |=> flags_load && !flags_value[vfi_pkg::FLAG_FAST] && pc_value == $past(ptr_q);
	endproperty
	a_fast_ret: assert property (p_fast_ret) else $error("fast return restore wrong");

	property p_ret_gie;
		@(posedge clk) disable iff (!rst_n_q)
		take_ret |=> mode_q[vfi_pkg::MODE_GIE];
	endproperty
	a_ret_gie: assert property (p_ret_gie) else $error("return left enable clear");

endmodule : vfi_core

// ### logic/vfi_pkg.sv
package vfi_pkg;

	// Register addresses on the core's register port
	localparam logic [7:0] ADDR_PTR_HIGH = 8'hda;
	localparam logic [7:0] ADDR_PTR_LOW = 8'hdb;
	localparam logic [7:0] ADDR_PEND = 8'hd4;
	localparam logic [7:0] ADDR_SYS_MODE = 8'hde;

	// Pending flags register layout
	localparam int PEND_WATCH = 7;
	localparam int PEND_RSVD = 6;
	localparam int PEND_D1_MATCH = 5;
	localparam int PEND_D1_OVF = 4;
	localparam int PEND_D0_MATCH = 3;
	localparam int PEND_D0_OVF = 2;
	localparam int PEND_A_MATCH = 1;
	localparam int PEND_A_OVF = 0;
	localparam logic [7:0] PEND_IMPL_MASK = 8'hbf;
	localparam logic [7:0] PEND_RESET = 8'h00;

	// System mode register fields
	localparam int MODE_GIE = 0;
	localparam int MODE_FAST_EN = 1;
	localparam int MODE_FSEL_LSB = 2;
	localparam int MODE_FSEL_MSB = 4;
	localparam logic [7:0] MODE_RESET = 8'h00;

	// Status flags field
	localparam int FLAG_FAST = 1;

	// Hardware-cleared request levels
	localparam int AUTO_LEVELS = 4;
	localparam logic [3:0] AUTO_RESET = 4'h0;

	// Vector area
	localparam logic [7:0] VEC_PAGE = 8'h00;

	typedef enum logic [11:0] {
		ST_IDLE = 12'h001,
		ST_PUSH_PCL = 12'h002,
		ST_PUSH_PCH = 12'h004,
		ST_PUSH_FLG = 12'h008,
		ST_FETCH_HI = 12'h010,
		ST_FETCH_LO = 12'h020,
		ST_BRANCH = 12'h040,
		ST_RET_FLG = 12'h080,
		ST_RET_PCH = 12'h100,
		ST_RET_PCL = 12'h200,
		ST_RET_DONE = 12'h400,
		ST_FAST = 12'h800
	} vfi_state_t;

endpackage : vfi_pkg

// ### logic/vfi_pending.sv
`timescale 1ns/1ps
module vfi_pending (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Source events
	input wire logic [7:0] src_event,
	// Register write
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	// Flag state
	output logic [7:0] flags
);

	logic [7:0] pend_q;
	logic [7:0] pend_d;

	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_bit
			if (vfi_pkg::PEND_IMPL_MASK[i]) begin : g_impl
				// Set wins over a clearing write; writing one keeps the bit
				assign pend_d[i] = src_event[i] | (pend_q[i] & ~(wr_en & ~wr_data[i]));
			end else begin : g_rsvd
				assign pend_d[i] = 1'b0;
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_q <= vfi_pkg::PEND_RESET;
		end else begin
			pend_q <= pend_d;
		end
	end

	assign flags = pend_q & vfi_pkg::PEND_IMPL_MASK;

	property p_pend_clear;
		@(posedge clk) disable iff (!rst_n)
		(wr_en && !wr_data[vfi_pkg::PEND_WATCH] && !src_event[vfi_pkg::PEND_WATCH])
			|=> !flags[vfi_pkg::PEND_WATCH];
	endproperty
	a_pend_clear: assert property (p_pend_clear) else $error("pending bit not cleared");

	property p_pend_keep;
		@(posedge clk) disable iff (!rst_n)
		(wr_en && wr_data[vfi_pkg::PEND_A_OVF] && flags[vfi_pkg::PEND_A_OVF])
			|=> flags[vfi_pkg::PEND_A_OVF];
	endproperty
	a_pend_keep: assert property (p_pend_keep) else $error("write of one lost a flag");

endmodule : vfi_pending

// ### sim/vfi_far_model.sv
`timescale 1ns/1ps
module vfi_far_model (
	// Clock
	input wire logic clk,
	// Stack side
	input wire logic push_en,
	input wire logic [7:0] push_data,
	input wire logic pop_en,
	output logic [7:0] pop_data,
	// Vector memory side
	input wire logic vec_rd_en,
	input wire logic [15:0] vec_rd_addr,
	output logic [7:0] vec_rd_data
);
	logic [7:0] stack_q [0:15];
	logic [3:0] sp_q = 4'h0;
	initial pop_data = 8'h00;
	initial vec_rd_data = 8'h00;
	// Last in, first out; popped byte lands the cycle after the pop
	always @(posedge clk) begin
		if (push_en) begin
			stack_q[sp_q] <= push_data;
			sp_q <= sp_q + 4'h1;
		end
		if (pop_en) begin
			pop_data <= stack_q[sp_q - 4'h1];
			sp_q <= sp_q - 4'h1;
		end else begin
			pop_data <= ~pop_data;
		end
	end
	// Vector area is 00h..FFh only; each byte reads as its address plus 30h
	always @(posedge clk) begin
		if (vec_rd_en && vec_rd_addr[15:8] == 8'h00) begin
			vec_rd_data <= vec_rd_addr[7:0] + 8'h30;
		end else begin
			vec_rd_data <= ~vec_rd_data;
		end
	end
endmodule : vfi_far_model

// ### sim/vfi_core_tb.sv
`timescale 1ns/1ps
module vfi_core_tb;
	logic clk = 1'b0;
	logic reset_n, instr_end, ret_req, gie_on, gie_off, win_valid, reg_wr, reg_rd;
	logic [7:0] src_event, win_vector, flags_in, reg_addr, reg_wdata, pop_data, vec_rd_data;
	logic [3:0] auto_event, auto_pending;
	logic [2:0] win_level, ack_level, lv;
	logic [15:0] pc_in, vec_rd_addr, pc_value;
	logic irq_ack, busy, push_en, pop_en, vec_rd_en, pc_load, flags_load;
	logic [7:0] push_data, flags_value, reg_rdata, sys_mode;
	logic a_ack [1:8];
	logic a_pop [1:8];
	logic a_busy [1:8];
	logic [8:0] a_push [1:8];
	logic [8:0] a_fl [1:8];
	logic [16:0] a_vec [1:8];
	logic [16:0] a_pcl [1:8];
	integer n_fail = 0;
	integer tests_run = 0;
	integer i;
	always #5 clk = ~clk;
	vfi_core u_dut (.clk(clk), .reset_n(reset_n), .src_event(src_event),
		.auto_event(auto_event), .auto_pending(auto_pending), .win_valid(win_valid),
		.win_level(win_level), .win_vector(win_vector), .instr_end(instr_end),
		.ret_req(ret_req), .gie_on(gie_on), .gie_off(gie_off), .pc_in(pc_in),
		.flags_in(flags_in), .irq_ack(irq_ack), .ack_level(ack_level), .busy(busy),
		.push_en(push_en), .push_data(push_data), .pop_en(pop_en), .pop_data(pop_data),
		.vec_rd_en(vec_rd_en), .vec_rd_addr(vec_rd_addr), .vec_rd_data(vec_rd_data),
		.pc_load(pc_load), .pc_value(pc_value), .flags_load(flags_load),
		.flags_value(flags_value), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sys_mode(sys_mode));
	vfi_far_model u_far (.clk(clk), .push_en(push_en), .push_data(push_data),
		.pop_en(pop_en), .pop_data(pop_data), .vec_rd_en(vec_rd_en),
		.vec_rd_addr(vec_rd_addr), .vec_rd_data(vec_rd_data));
	task automatic finish_test();
		$display("checks %0d fails %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : finish_test
	task automatic chk(input logic [16:0] got, input logic [16:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic step();
		@(posedge clk);
		#1;
	endtask : step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		step();
		reg_wr = 1'b0;
		step();
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_addr = a;
		reg_rd = 1'b1;
		step();
		reg_rd = 1'b0;
		chk(reg_rdata, e);
		step();
	endtask : rd
	// One instruction end, then the eight cycles after it are recorded
	task automatic take();
		integer k;
		instr_end = 1'b1;
		step();
		instr_end = 1'b0;
		for (k = 1; k <= 8; k++) begin
			a_ack[k] = irq_ack;
			a_pop[k] = pop_en;
			a_busy[k] = busy;
			a_push[k] = {push_en, push_data};
			a_fl[k] = {flags_load, flags_value};
			a_vec[k] = {vec_rd_en, vec_rd_addr};
			a_pcl[k] = {pc_load, pc_value};
			step();
		end
	endtask : take
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		finish_test();
	end
	initial begin
		reset_n = 0; src_event = 0; auto_event = 0; win_valid = 0; win_level = 0;
		win_vector = 0; instr_end = 0; ret_req = 0; gie_on = 0; gie_off = 0;
		pc_in = 16'h1234; flags_in = 8'h80; reg_addr = 0; reg_wr = 0; reg_rd = 0;
		reg_wdata = 0; lv = 0;
		repeat (8) @(posedge clk);
		#1 reset_n = 1'b1;
		repeat (3) step();
		rd(vfi_pkg::ADDR_PEND, 8'h00);
		rd(vfi_pkg::ADDR_SYS_MODE, 8'h00);
		chk(auto_pending, 4'h0);
		src_event = 8'hff;
		step();
		src_event = 8'h00;
		rd(vfi_pkg::ADDR_PEND, 8'hbf);
		wr(vfi_pkg::ADDR_PEND, 8'hfd);
		rd(vfi_pkg::ADDR_PEND, 8'hbd);
		wr(vfi_pkg::ADDR_PEND, 8'h00);
		rd(vfi_pkg::ADDR_PEND, 8'h00);
		wr(vfi_pkg::ADDR_PTR_HIGH, 8'h56);
		wr(vfi_pkg::ADDR_PTR_LOW, 8'h78);
		rd(vfi_pkg::ADDR_PTR_HIGH, 8'h56);
		rd(vfi_pkg::ADDR_PTR_LOW, 8'h78);
		rd(8'h10, 8'h00);
		win_valid = 1'b1;
		win_vector = 8'h24;
		auto_event = 4'h1;
		step();
		auto_event = 4'h0;
		chk(auto_pending, 4'h1);
		take();
		chk(a_ack[1], 1'b0);
		wr(vfi_pkg::ADDR_SYS_MODE, 8'h01);
		repeat (3) begin
			step();
			chk(irq_ack, 1'b0);
		end
		take();
		chk(a_ack[1], 1'b1);
		chk(ack_level, 3'h0);
		chk(a_push[1], 9'h134);
		chk(a_push[2], 9'h112);
		chk(a_push[3], 9'h180);
		chk(a_vec[4], 17'h10024);
		chk(a_vec[5], 17'h10025);
		chk(a_pcl[7], 17'h15455);
		chk(sys_mode[0], 1'b0);
		chk(auto_pending, 4'h0);
		pc_in = 16'h4000;
		flags_in = 8'h00;
		ret_req = 1'b1;
		take();
		ret_req = 1'b0;
		chk({a_pop[1], a_pop[2], a_pop[3]}, 3'h7);
		chk(a_pcl[5], 17'h11234);
		chk(a_fl[5], 9'h180);
		chk(sys_mode[0], 1'b1);
		for (i = 0; i < 8; i++) begin
			lv = i[2:0];
			win_level = lv;
			wr(vfi_pkg::ADDR_PTR_HIGH, 8'h60);
			wr(vfi_pkg::ADDR_PTR_LOW, {4'h0, lv, 1'b0});
			wr(vfi_pkg::ADDR_SYS_MODE, {3'h0, lv, 2'b11});
			pc_in = {8'h22, 5'h0, lv};
			flags_in = 8'h81;
			take();
			chk(a_ack[1], 1'b1);
			chk(a_pcl[1], {1'b1, 8'h60, 4'h0, lv, 1'b0});
			chk(a_fl[1], 9'h183);
			chk(a_push[1][8], 1'b0);
			rd(vfi_pkg::ADDR_PTR_HIGH, 8'h22);
			rd(vfi_pkg::ADDR_SYS_MODE, {3'h0, lv, 2'b10});
			pc_in = 16'h7000;
			flags_in = 8'h03;
			ret_req = 1'b1;
			take();
			ret_req = 1'b0;
			chk(a_pcl[1], {1'b1, 8'h22, 5'h0, lv});
			chk(a_fl[1], 9'h181);
			rd(vfi_pkg::ADDR_PTR_HIGH, 8'h70);
		end
		win_level = 3'h2;
		win_vector = 8'h25;
		flags_in = 8'h80;
		wr(vfi_pkg::ADDR_SYS_MODE, 8'h09);
		take();
		chk(a_push[1], 9'h100);
		chk(a_pcl[1][16], 1'b0);
		chk(a_vec[4], 17'h10024);
		chk(a_busy[6], 1'b1);
		chk(a_busy[7], 1'b0);
		// Routine re-enables for nesting; a second request is then taken
		gie_on = 1'b1;
		step();
		gie_on = 1'b0;
		chk(sys_mode, 8'h09);
		win_level = 3'h3;
		take();
		chk(a_ack[1], 1'b1);
		chk(ack_level, 3'h3);
		chk(a_push[3], 9'h180);
		gie_on = 1'b1;
		step();
		gie_on = 1'b0;
		gie_off = 1'b1;
		step();
		gie_off = 1'b0;
		chk(sys_mode, 8'h08);
		take();
		chk(a_ack[1], 1'b0);
		finish_test();
	end
endmodule : vfi_core_tb
